// [common/lpa_pkg.sv]
// link partner ability register: offsets, field positions, masks, reset values
// assumes a 16-bit management data path and 5-bit register addresses
package lpa_pkg;

  localparam int          LPA_DATA_W      = 16;
  localparam int          LPA_ADDR_W      = 5;
  localparam logic [4:0]  LPA_REG_ADDR    = 5'h05;
  localparam logic [15:0] LPA_RESET_VALUE = 16'h0000;

  // field positions
  localparam int LPA_NEXT_PAGE_BIT   = 15;
  localparam int LPA_ACK_BIT         = 14;
  localparam int LPA_REMOTE_FAULT    = 13;
  localparam int LPA_RSVD_HI         = 12;
  localparam int LPA_RSVD_LO         = 10;
  localparam int LPA_T4_BIT          = 9;
  localparam int LPA_TX_FD_BIT       = 8;
  localparam int LPA_TX_HD_BIT       = 7;
  localparam int LPA_10_FD_BIT       = 6;
  localparam int LPA_10_HD_BIT       = 5;
  localparam int LPA_SEL_HI          = 4;
  localparam int LPA_SEL_LO          = 0;

  // bits that hold partner data; reserved 12:10 and 9 stay zero
  localparam logic [15:0] LPA_LOAD_MASK   = 16'hE1FF;
  // selector bits 3:0 take management writes under override
  localparam logic [15:0] LPA_CW_MASK     = 16'h000F;

  // selector codes
  localparam logic [4:0]  LPA_SEL_8023    = 5'h01;
  localparam logic [4:0]  LPA_SEL_8029    = 5'h02;

endpackage

// [common/lpa_wr_if.sv]
// write path between the register and its override write gate
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lpa_wr_if;
  import lpa_pkg::*;

  logic                  wr_en;
  logic [LPA_ADDR_W-1:0] wr_addr;
  logic [LPA_DATA_W-1:0] wr_data;
  logic                  override;
  logic                  cw_we;
  logic [LPA_DATA_W-1:0] cw_data;

  modport reg_side  (output wr_en, output wr_addr, output wr_data, output override,
                     input cw_we, input cw_data);
  modport gate_side (input wr_en, input wr_addr, input wr_data, input override,
                     output cw_we, output cw_data);
endinterface

// [hw/lpa_cw_gate.sv]
// override write gate: passes management writes to selector bits 3:0 only
// assumes the override level is already synchronous to clk_sys
`timescale 1ns/1ps
module lpa_cw_gate
  import lpa_pkg::*;
(
  // write path
  lpa_wr_if.gate_side wr
);

  // writes are isolated unless the override bit is set
  assign wr.cw_we   = wr.wr_en && (wr.wr_addr == LPA_REG_ADDR) && wr.override;
  // only the selector bits 3:0 are writable, everything else is read only
  assign wr.cw_data = wr.wr_data & LPA_CW_MASK;

endmodule

// [hw/lpa_reg.sv]
// link partner ability register with its management read/write port
// assumes decoded management frames arrive as single-cycle strobes on clk_sys
// and that the negotiation receiver presents each base page as a one-cycle pulse
//
// Function
// - All bits except 12 to 9 are loaded from the received base page while negotiation runs.
// - Bit 15 shows the partner's next page flag, one meaning more pages follow.
// - Bit 14 shows one once the partner has acknowledged our code word.
// - Bit 13 copies the partner's remote fault flag.
// - Bits 8 to 5 show partner ability for 100 full, 100 half, 10 full, 10 half.
// - Bit 9, the four-pair ability, always reads zero.
// - Reserved bits 12 to 10 always read zero.
// - Bits 4 to 0 hold the partner selector code, only 00001b is supported.
// - Selector bits 3 to 0 are override-writable, all others read only, reset zero.
// - Override writes are ignored unless the override bit is one.
`timescale 1ns/1ps
module lpa_reg
  import lpa_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // management access
  input  wire logic                  mgmt_rd_en,
  input  wire logic                  mgmt_wr_en,
  input  wire logic [LPA_ADDR_W-1:0] mgmt_addr,
  input  wire logic [LPA_DATA_W-1:0] mgmt_wr_data,
  output logic      [LPA_DATA_W-1:0] mgmt_rd_data,
  output logic                       mgmt_rd_valid,
  // command register override level
  input  wire logic                  cmd_override,
  // received base page from the negotiation receiver
  input  wire logic                  an_busy,
  input  wire logic                  page_valid,
  input  wire logic [LPA_DATA_W-1:0] page_word,
  // status towards the rest of the device
  output logic                       page_loaded,
  output logic                       partner_next_page,
  output logic                       partner_sel_ok
);

  logic [LPA_DATA_W-1:0] ability;
  logic [LPA_DATA_W-1:0] next_ability;
  logic                  page_take;

  lpa_wr_if wr ();

  assign wr.wr_en    = mgmt_wr_en;
  assign wr.wr_addr  = mgmt_addr;
  assign wr.wr_data  = mgmt_wr_data;
  assign wr.override = cmd_override;

  lpa_cw_gate u_gate
  (
    .wr (wr.gate_side)
  );

  // a page is only captured while negotiation is in progress
  assign page_take = page_valid && an_busy;

  // page load wins over a same-cycle override write: partner data is the truth
  always_comb
  begin
    next_ability = ability;
    if (page_take)
    begin
      // next page, ack, fault, abilities and selector; 12:9 forced low
      next_ability = page_word & LPA_LOAD_MASK;
    end
    else if (wr.cw_we)
    begin
      next_ability = (ability & ~LPA_CW_MASK) | wr.cw_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ability <= LPA_RESET_VALUE;
    else
      ability <= next_ability;
  end

  // read port: one cycle latency, unmapped addresses return zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mgmt_rd_data  <= LPA_RESET_VALUE;
      mgmt_rd_valid <= 1'b0;
    end
    else
    begin
      mgmt_rd_valid <= mgmt_rd_en;
      if (mgmt_rd_en && (mgmt_addr == LPA_REG_ADDR))
        mgmt_rd_data <= ability & LPA_LOAD_MASK;
      else if (mgmt_rd_en)
        mgmt_rd_data <= LPA_RESET_VALUE;
    end
  end

  // next page and selector flags follow the stored word; page_loaded marks a captured page
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      page_loaded       <= 1'b0;
      partner_next_page <= 1'b0;
      partner_sel_ok    <= 1'b0;
    end
    else
    begin
      page_loaded       <= page_take;
      partner_next_page <= next_ability[LPA_NEXT_PAGE_BIT];
      // only the 802.3 selector is usable; 802.9 is valid but unsupported
      partner_sel_ok    <= (next_ability[LPA_SEL_HI:LPA_SEL_LO] == LPA_SEL_8023);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_page_in;
    page_valid && an_busy;
  endsequence

  sequence s_cw_write;
    mgmt_wr_en && (mgmt_addr == LPA_REG_ADDR) && !page_take;
  endsequence

  sequence s_quiet;
    !page_take && !(mgmt_wr_en && (mgmt_addr == LPA_REG_ADDR));
  endsequence

  a_page_load_value: assert property (
    s_page_in |=> (ability == ($past(page_word) & LPA_LOAD_MASK)) && page_loaded)
    else $error("received page not captured");

  a_page_fields_copy: assert property (
    s_page_in |=> ability[LPA_REMOTE_FAULT] == $past(page_word[LPA_REMOTE_FAULT])
      && ability[LPA_NEXT_PAGE_BIT] == $past(page_word[LPA_NEXT_PAGE_BIT])
      && ability[LPA_ACK_BIT] == $past(page_word[LPA_ACK_BIT])
      && partner_next_page == $past(page_word[LPA_NEXT_PAGE_BIT]))
    else $error("flag bits differ from received page");

  a_reserved_read_zero: assert property (
    mgmt_rd_valid |-> mgmt_rd_data[LPA_RSVD_HI:LPA_T4_BIT] == 4'h0)
    else $error("reserved or four-pair bit reads nonzero");

  a_cw_blocked_write: assert property (
    (s_cw_write and !cmd_override) |=> $stable(ability))
    else $error("write changed register without override");

  a_cw_write_takes: assert property (
    (s_cw_write and cmd_override) |=>
      ability[3:0] == $past(mgmt_wr_data[3:0]) && ability[15:4] == $past(ability[15:4]))
    else $error("override write wrong or touched read-only bits");

  a_idle_holds_value: assert property (
    s_quiet ##1 s_quiet |=> $stable(ability))
    else $error("register changed without cause");

  a_read_returns_reg: assert property (
    (mgmt_rd_en && mgmt_addr == LPA_REG_ADDR) |=>
      mgmt_rd_valid && mgmt_rd_data == ($past(ability) & LPA_LOAD_MASK))
    else $error("read data or valid wrong");

  a_reset_to_zero: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> ability == LPA_RESET_VALUE && !mgmt_rd_valid && !page_loaded)
    else $error("reset value not zero");

  a_selector_flag: assert property (
    s_page_in |=> partner_sel_ok == ($past(page_word[4:0]) == LPA_SEL_8023))
    else $error("selector support flag wrong");

  sequence s_page_refused;
    page_valid && !an_busy;
  endsequence

  sequence s_no_reg_write;
    !(mgmt_wr_en && (mgmt_addr == LPA_REG_ADDR));
  endsequence

  // a page seen outside negotiation must leave no trace
  a_refused_page_quiet: assert property (
    (s_page_refused and s_no_reg_write) |=> $stable(ability) && !page_loaded)
    else $error("page taken while negotiation idle");

  a_loaded_only_on_page: assert property (
    !page_take |=> !page_loaded)
    else $error("page loaded flag without a captured page");

  a_ack_bit_copy: assert property (
    s_page_in |=> ability[LPA_ACK_BIT] == $past(page_word[LPA_ACK_BIT]))
    else $error("acknowledge bit differs from received page");

  a_ability_bits_copy: assert property (
    s_page_in |=> ability[LPA_TX_FD_BIT:LPA_10_HD_BIT]
      == $past(page_word[LPA_TX_FD_BIT:LPA_10_HD_BIT]))
    else $error("ability bits differ from received page");

  a_selector_copy: assert property (
    s_page_in |=> ability[LPA_SEL_HI:LPA_SEL_LO] == $past(page_word[LPA_SEL_HI:LPA_SEL_LO]))
    else $error("selector bits differ from received page");

  // status levels must never drift from the stored word
  a_status_tracks_reg: assert property (
    partner_next_page == ability[LPA_NEXT_PAGE_BIT]
      && partner_sel_ok == (ability[LPA_SEL_HI:LPA_SEL_LO] == LPA_SEL_8023))
    else $error("status flags disagree with stored word");

  a_stored_rsvd_zero: assert property (
    ability[LPA_RSVD_HI:LPA_T4_BIT] == 4'h0)
    else $error("reserved or four-pair bit stored nonzero");

  a_write_keeps_ro: assert property (
    s_cw_write |=> ability[LPA_DATA_W-1:LPA_SEL_HI] == $past(ability[LPA_DATA_W-1:LPA_SEL_HI]))
    else $error("write changed a read-only bit");

endmodule

// [verif/lpa_partner.sv]
// remote link partner: presents received base pages to the register
// assumes the bench calls send_page from its main sequence
`timescale 1ns/1ps
module lpa_partner
  import lpa_pkg::*;
(
  // clock
  input  wire logic                  clk_sys,
  // received page towards the register
  output logic                       an_busy,
  output logic                       page_valid,
  output logic      [LPA_DATA_W-1:0] page_word
);
  logic [LPA_DATA_W-1:0] word_q;
  logic [LPA_DATA_W-1:0] idle_pat = 16'h5A5A;
  initial
  begin
    an_busy    = 1'b0;
    page_valid = 1'b0;
    word_q     = 16'h0000;
  end
  // stale data never lingers between pages
  always @(posedge clk_sys) idle_pat <= ~idle_pat;
  assign page_word = page_valid ? word_q : idle_pat;
  task automatic send_page(input logic [15:0] w, input logic busy);
    @(posedge clk_sys);
    #1;
    an_busy    = busy;
    page_valid = 1'b1;
    word_q     = w;
    @(posedge clk_sys);
    #1;
    page_valid = 1'b0;
    an_busy    = 1'b0;
  endtask
endmodule

// [verif/lpa_reg_test.sv]
// self-checking bench for the link partner ability register
// assumes lpa_partner models the far end of the negotiation link
`timescale 1ns/1ps
module lpa_reg_test;
  import lpa_pkg::*;
  logic        clk_sys, reset, rd_en, wr_en, ovr, rd_valid, loaded, np, sel_ok, busy, pv;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, pw, got;
  logic [15:0] pages [4] = '{16'hFFFF, 16'h6141, 16'h8021, 16'h0002};
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  lpa_partner u_lpa_partner (.clk_sys(clk_sys), .an_busy(busy), .page_valid(pv),
                             .page_word(pw));
  lpa_reg u_lpa_reg (.clk_sys(clk_sys), .reset(reset), .mgmt_rd_en(rd_en),
    .mgmt_wr_en(wr_en), .mgmt_addr(addr), .mgmt_wr_data(wdata), .mgmt_rd_data(rdata),
    .mgmt_rd_valid(rd_valid), .cmd_override(ovr), .an_busy(busy), .page_valid(pv),
    .page_word(pw), .page_loaded(loaded), .partner_next_page(np), .partner_sel_ok(sel_ok));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole run needs about 40 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    if (g !== e)
      error_cnt++;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    #1 rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys);
    #1 rd_en = 1'b0;
    chk({15'h0, rd_valid}, 16'h0001);
    got = rdata;
  endtask
  task automatic wr(input logic [15:0] d, input logic o);
    @(posedge clk_sys);
    #1 wr_en = 1'b1;
    addr = 5'h05;
    wdata = d;
    ovr = o;
    @(posedge clk_sys);
    #1 wr_en = 1'b0;
  endtask
  task automatic t_reset();
    rd(5'h05);
    chk(got, 16'h0000);
    chk({13'h0, loaded, np, sel_ok}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_pages();
    foreach (pages[i])
    begin
      u_lpa_partner.send_page(pages[i], 1'b1);
      chk({15'h0, loaded}, 16'h0001);
      chk({15'h0, np}, {15'h0, pages[i][15]});
      chk({15'h0, sel_ok}, {15'h0, pages[i][4:0] == 5'h01});
      // read only once the partner has dropped negotiation busy
      rd(5'h05);
      chk(got, pages[i] & LPA_LOAD_MASK);
    end
    $display("page load test done");
  endtask
  task automatic t_idle_page();
    u_lpa_partner.send_page(16'hFFFF, 1'b0);
    chk({15'h0, loaded}, 16'h0000);
    rd(5'h05);
    chk(got, 16'h0002);
    rd(5'h06);
    chk(got, 16'h0000);
    $display("idle page test done");
  endtask
  task automatic t_override();
    wr(16'h000F, 1'b0);
    rd(5'h05);
    chk(got, 16'h0002);
    wr(16'h800D, 1'b1);
    rd(5'h05);
    chk(got, 16'h000D);
    $display("override write test done");
  endtask
  // reset with live partner data must clear register and status
  task automatic t_mid_reset();
    u_lpa_partner.send_page(16'hA1E1, 1'b1);
    @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    rd(5'h05);
    chk(got, LPA_RESET_VALUE);
    chk({13'h0, loaded, np, sel_ok}, 16'h0000);
    $display("mid-run reset test done");
  endtask
  initial
  begin
    reset = 1'b1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    ovr = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_reset();
    t_pages();
    t_idle_page();
    t_override();
    t_mid_reset();
    end_of_test();
  end
endmodule
